// *** hw/cflg_gate.sv ***
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: supply field 0x1 is dual, 0x2 single, 0x0 and 0x3 reserved.
// R2: hold code execution 0 ms, or 1 ms doubling to 64 ms by field.
// R3: code size fuse is boot plus application length in 512-byte blocks.
// R4: boot size fuse is boot length in 512-byte blocks.
// R5: boot size zero makes the whole flash the boot region.
// R6: fuses come from nonvolatile storage and read back as read-only registers.
// R7: unlocked only when the 32-bit key equals 0x5cc5c55c exactly.
// R8: host locks the part by storing any other key value.
// R9: cpu access ignores the lock; signature row, fuses, key never cpu-writable.
// R10: unlocked host reads and writes all, signature row read-only.
// R11: locked host gets nothing except user row writes.
// R12: denied host reads complete normally but return no memory content.
// R13: locked user row writes only via fuse command, and stay unreadable.
// R14: only a full erase unlocks; user row survives, application data goes.
// R15: erase of a locked part always erases eeprom.
// R16: lock status follows every change of the stored key, including load.
module cflg_gate #(
  parameter int STARTUP_UNIT_CYCLES = cflg_pkg::STARTUP_UNIT_CYCLES,
  parameter logic [8:0] FLASH_BLOCKS = cflg_pkg::FLASH_BLOCKS_DEFAULT
) (
  input wire logic core_clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic [cflg_pkg::ADDR_W-1:0] s_axi_awaddr_in, // write address
  input wire logic s_axi_awvalid_in, // write address valid
  output logic s_axi_awready_out, // write address ready
  input wire logic [31:0] s_axi_wdata_in, // write data
  input wire logic [3:0] s_axi_wstrb_in, // write strobes
  input wire logic s_axi_wvalid_in, // write data valid
  output logic s_axi_wready_out, // write data ready
  output logic [1:0] s_axi_bresp_out, // write response
  output logic s_axi_bvalid_out, // write response valid
  input wire logic s_axi_bready_in, // write response ready
  input wire logic [cflg_pkg::ADDR_W-1:0] s_axi_araddr_in, // read address
  input wire logic s_axi_arvalid_in, // read address valid
  output logic s_axi_arready_out, // read address ready
  output logic [31:0] s_axi_rdata_out, // read data
  output logic [1:0] s_axi_rresp_out, // read response
  output logic s_axi_rvalid_out, // read data valid
  input wire logic s_axi_rready_in, // read data ready
  input wire logic [31:0] nv_key_in, // stored lock key
  input wire logic [7:0] nv_sys_cfg1_in, // stored system config one fuse
  input wire logic [7:0] nv_code_size_in, // stored code region size fuse
  input wire logic [7:0] nv_boot_size_in, // stored boot region size fuse
  input wire logic nv_eeprom_keep_in, // stored eeprom_keep_on_erase bit
  input wire logic nv_reload_in, // pulse: storage contents changed
  input wire logic host_req_valid_in, // pulse: debug_program_port access
  input wire logic host_req_write_in, // host access is a write
  input wire logic host_req_fuse_cmd_in, // host write via fuse-write command
  input wire cflg_pkg::cflg_section_t host_req_section_in, // host target section
  input wire logic [7:0] host_mem_rdata_in, // memory data for host read
  output logic host_ack_out, // host access done
  output logic host_grant_out, // host access permitted
  output logic [7:0] host_rdata_out, // data returned to host
  input wire logic host_erase_req_in, // pulse: full_device_erase request
  input wire logic cpu_req_valid_in, // pulse: cpu access
  input wire logic cpu_req_write_in, // cpu access is a write
  input wire cflg_pkg::cflg_section_t cpu_req_section_in, // cpu target section
  output logic cpu_ack_out, // cpu access done
  output logic cpu_grant_out, // cpu access permitted
  output logic erase_start_out, // pulse: start array erase
  output logic erase_eeprom_out, // eeprom included in erase
  input wire logic erase_done_in, // pulse: array erase finished
  output logic key_store_write_out, // pulse: store key_store_data_out
  output logic [31:0] key_store_data_out, // key value to store
  output logic unlocked_out, // device unlocked
  output logic supply_dual_out, // split_supply_io dual supply
  output logic supply_single_out, // single supply
  output logic supply_reserved_out, // reserved supply code
  output logic [8:0] boot_blocks_out, // boot region length in blocks
  output logic [8:0] code_blocks_out, // boot plus app length in blocks
  output logic code_run_out // start-up delay over, code may run
);

  // ==========================================================
  // fuse and key holding registers
  // ==========================================================
  logic [31:0] key_q;
  logic [7:0] sys_cfg1_q;
  logic [7:0] code_size_q;
  logic [7:0] boot_size_q;
  logic eeprom_keep_q;
  logic erase_busy;
  logic reload_pulse;
  cflg_pkg::cflg_state_t state;
  cflg_pkg::cflg_state_t next_state;
  logic [31:0] dly_cnt;

  wire logic capture = (state == cflg_pkg::ST_LOAD) || nv_reload_in || reload_pulse; // [R16]
  wire logic key_ok = (key_q == cflg_pkg::UNLOCK_KEY); // [R7]
  wire logic [1:0] supply_sel = sys_cfg1_q[cflg_pkg::SUPPLY_LSB +: 2];
  wire logic [2:0] startup_sel = sys_cfg1_q[cflg_pkg::STARTUP_LSB +: 3];
  // a key is stored externally by the erase, so the mirror takes it at done
  wire logic erase_finish = erase_busy && erase_done_in;

  // storage is read after the reset release, never under it
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      key_q <= cflg_pkg::KEY_RESET;
      sys_cfg1_q <= cflg_pkg::FUSE_RESET;
      code_size_q <= cflg_pkg::FUSE_RESET;
      boot_size_q <= cflg_pkg::FUSE_RESET;
      eeprom_keep_q <= 1'b0;
    end
    else if (erase_finish)
    begin
      key_q <= cflg_pkg::UNLOCK_KEY; // [R14]
    end
    else if (capture)
    begin
      key_q <= nv_key_in; // [R6] [R8] [R16]
      sys_cfg1_q <= nv_sys_cfg1_in;
      code_size_q <= nv_code_size_in;
      boot_size_q <= nv_boot_size_in;
      eeprom_keep_q <= nv_eeprom_keep_in;
    end
  end

  // ==========================================================
  // start-up delay
  // ==========================================================
  wire logic [31:0] dly_target = 32'(STARTUP_UNIT_CYCLES) << (startup_sel - 3'h1); // [R2]
  wire logic dly_over = (dly_cnt >= dly_target - 32'h1);

  always_comb
  begin
    case (state)
      cflg_pkg::ST_LOAD: next_state = cflg_pkg::ST_DELAY;
      cflg_pkg::ST_DELAY:
        next_state = (startup_sel == cflg_pkg::STARTUP_NONE || dly_over) ? cflg_pkg::ST_RUN
                                                                         : cflg_pkg::ST_DELAY;
      cflg_pkg::ST_RUN: next_state = cflg_pkg::ST_RUN;
      default: next_state = cflg_pkg::ST_LOAD;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      state <= cflg_pkg::ST_LOAD;
      dly_cnt <= 32'h0;
    end
    else
    begin
      state <= next_state;
      dly_cnt <= (state == cflg_pkg::ST_DELAY) ? dly_cnt + 32'h1 : 32'h0; // [R2]
    end
  end

  // ==========================================================
  // decoded fuse outputs
  // ==========================================================
  wire logic boot_whole = (boot_size_q == cflg_pkg::FUSE_RESET);
  wire logic [8:0] next_boot = boot_whole ? FLASH_BLOCKS : {1'b0, boot_size_q}; // [R4] [R5]
  wire logic [8:0] next_code = boot_whole ? FLASH_BLOCKS : {1'b0, code_size_q}; // [R3] [R5]

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      supply_dual_out <= 1'b0;
      supply_single_out <= 1'b0;
      supply_reserved_out <= 1'b0;
      boot_blocks_out <= 9'h000;
      code_blocks_out <= 9'h000;
      code_run_out <= 1'b0;
      unlocked_out <= 1'b0;
    end
    else
    begin
      supply_dual_out <= (supply_sel == cflg_pkg::SUPPLY_DUAL); // [R1]
      supply_single_out <= (supply_sel == cflg_pkg::SUPPLY_SINGLE); // [R1]
      supply_reserved_out <= (supply_sel != cflg_pkg::SUPPLY_DUAL) &&
                             (supply_sel != cflg_pkg::SUPPLY_SINGLE); // [R1]
      boot_blocks_out <= next_boot;
      code_blocks_out <= next_code;
      code_run_out <= (state == cflg_pkg::ST_RUN);
      unlocked_out <= key_ok; // [R7] [R16]
    end
  end

  // ==========================================================
  // access gating for host and cpu
  // ==========================================================
  logic host_allow;
  logic cpu_allow;

  cflg_access_check u_host_chk (
    .is_host_in(1'b1),
    .unlocked_in(key_ok),
    .write_in(host_req_write_in),
    .fuse_cmd_in(host_req_fuse_cmd_in),
    .section_in(host_req_section_in),
    .allow_out(host_allow)
  );

  cflg_access_check u_cpu_chk (
    .is_host_in(1'b0),
    .unlocked_in(key_ok),
    .write_in(cpu_req_write_in),
    .fuse_cmd_in(1'b0),
    .section_in(cpu_req_section_in),
    .allow_out(cpu_allow)
  );

  // host is held off while an erase is running so it cannot read half-erased data
  wire logic host_ok = host_allow && !erase_busy; // [R10] [R11] [R13]
  wire logic host_rd_ok = host_ok && !host_req_write_in;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      host_ack_out <= 1'b0;
      host_grant_out <= 1'b0;
      host_rdata_out <= 8'h00;
      cpu_ack_out <= 1'b0;
      cpu_grant_out <= 1'b0;
    end
    else
    begin
      host_ack_out <= host_req_valid_in; // [R12]
      host_grant_out <= host_req_valid_in && host_ok;
      host_rdata_out <= (host_req_valid_in && host_rd_ok) ? host_mem_rdata_in : 8'h00; // [R12]
      cpu_ack_out <= cpu_req_valid_in;
      cpu_grant_out <= cpu_req_valid_in && cpu_allow; // [R9]
    end
  end

  // ==========================================================
  // full device erase
  // ==========================================================
  wire logic erase_go = host_erase_req_in && !erase_busy;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      erase_busy <= 1'b0;
      erase_start_out <= 1'b0;
      erase_eeprom_out <= 1'b0;
      key_store_write_out <= 1'b0;
      key_store_data_out <= 32'h0;
    end
    else
    begin
      erase_start_out <= erase_go; // [R14]
      key_store_write_out <= erase_finish; // [R14]
      key_store_data_out <= cflg_pkg::UNLOCK_KEY;
      if (erase_go)
      begin
        erase_busy <= 1'b1;
        erase_eeprom_out <= !eeprom_keep_q || !key_ok; // [R15]
      end
      else if (erase_finish)
      begin
        erase_busy <= 1'b0;
        erase_eeprom_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // axi4-lite register slave
  // ==========================================================
  function automatic logic reg_hit(input logic [cflg_pkg::ADDR_W-1:0] a, input logic [5:0] idx);
    reg_hit = (a == {idx, 2'b00});
  endfunction

  logic aw_held;
  logic w_held;
  logic [cflg_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  wire logic aw_take = s_axi_awvalid_in && s_axi_awready_out;
  wire logic w_take = s_axi_wvalid_in && s_axi_wready_out;
  wire logic wr_fire = aw_held && w_held;
  wire logic ar_take = s_axi_arvalid_in && s_axi_arready_out;

  // fuse and key mirrors are read-only from the bus side
  wire logic wr_ro = reg_hit(aw_addr, cflg_pkg::IDX_KEY) ||
                     reg_hit(aw_addr, cflg_pkg::IDX_SYS_CFG1) ||
                     reg_hit(aw_addr, cflg_pkg::IDX_CODE_SIZE) ||
                     reg_hit(aw_addr, cflg_pkg::IDX_BOOT_SIZE) ||
                     reg_hit(aw_addr, cflg_pkg::IDX_STATUS); // [R9]
  wire logic wr_ctl = reg_hit(aw_addr, cflg_pkg::IDX_CONTROL);
  wire logic [1:0] wr_resp = wr_ctl ? cflg_pkg::RESP_OKAY :
                             wr_ro ? cflg_pkg::RESP_SLVERR : cflg_pkg::RESP_DECERR;

  wire logic [31:0] status_word = {28'h0, erase_busy, code_run_out,
                                   (state != cflg_pkg::ST_LOAD), key_ok};
  wire logic rd_key = reg_hit(s_axi_araddr_in, cflg_pkg::IDX_KEY);
  wire logic rd_cfg = reg_hit(s_axi_araddr_in, cflg_pkg::IDX_SYS_CFG1);
  wire logic rd_code = reg_hit(s_axi_araddr_in, cflg_pkg::IDX_CODE_SIZE);
  wire logic rd_boot = reg_hit(s_axi_araddr_in, cflg_pkg::IDX_BOOT_SIZE);
  wire logic rd_stat = reg_hit(s_axi_araddr_in, cflg_pkg::IDX_STATUS);
  wire logic rd_ctl = reg_hit(s_axi_araddr_in, cflg_pkg::IDX_CONTROL);
  wire logic rd_map = rd_key || rd_cfg || rd_code || rd_boot || rd_stat || rd_ctl;
  wire logic [31:0] rd_word = rd_key ? key_q : // [R6]
                              rd_cfg ? {24'h0, sys_cfg1_q} :
                              rd_code ? {24'h0, code_size_q} :
                              rd_boot ? {24'h0, boot_size_q} :
                              rd_stat ? status_word : 32'h0;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_lane0 <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= cflg_pkg::RESP_OKAY;
      reload_pulse <= 1'b0;
    end
    else
    begin
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_take)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_lane0 <= s_axi_wstrb_in[0];
      end
      reload_pulse <= wr_fire && wr_ctl && w_lane0 && w_data[cflg_pkg::CTL_BIT_RELOAD];
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_resp;
      end
      else if (s_axi_bready_in)
      begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= cflg_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_word;
      s_axi_rresp_out <= rd_map ? cflg_pkg::RESP_OKAY : cflg_pkg::RESP_DECERR;
    end
    else if (s_axi_rready_in)
    begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_erase_issue;
    host_erase_req_in && !erase_busy;
  endsequence
  sequence s_erase_end;
    erase_busy && erase_done_in;
  endsequence

  a_erase_unlocks: assert property (s_erase_end |=> ##1 unlocked_out) // [R14]
    else $error("erase completion did not unlock");
  a_erase_locked_ee: assert property (s_erase_issue ##0 !key_ok |=> // [R15]
    erase_start_out && erase_eeprom_out)
    else $error("locked erase skipped eeprom");
  a_key_load_track: assert property (rst_n_in && (state == cflg_pkg::ST_LOAD) |=> ##1
                                      unlocked_out == ($past(nv_key_in, 2) == cflg_pkg::UNLOCK_KEY)) // [R7]
    else $error("lock status does not follow loaded key");
  a_host_locked_deny: assert property (host_req_valid_in && !key_ok && !host_req_fuse_cmd_in
                                       |=> host_ack_out && !host_grant_out) // [R11]
    else $error("locked host access granted");
  a_denied_no_data: assert property (host_ack_out && !host_grant_out |-> // [R12]
    host_rdata_out == 8'h00)
    else $error("denied host read leaked data");
  a_host_sign_ro: assert property (host_req_valid_in && host_req_write_in && // [R10]
    host_req_section_in == cflg_pkg::SEC_SIGNATURE |=> !host_grant_out)
    else $error("host wrote signature row");
  a_cpu_ignores_lock: assert property (cpu_req_valid_in && !cpu_req_write_in |=> // [R9]
    cpu_ack_out && cpu_grant_out)
    else $error("cpu read refused");
  a_user_row_hidden: assert property (host_req_valid_in && !key_ok && !host_req_write_in &&
                                      host_req_section_in == cflg_pkg::SEC_USER_ROW |=> !host_grant_out) // [R13]
    else $error("locked host read user row");
  a_boot_whole: assert property (rst_n_in && boot_size_q == 8'h00 |=> // [R5]
    boot_blocks_out == FLASH_BLOCKS)
    else $error("zero boot size not whole flash");
  a_supply_dual: assert property (supply_sel == 2'h1 |=> supply_dual_out && !supply_single_out) // [R1]
    else $error("dual supply code misdecoded");
  a_startup_hold: assert property (state == cflg_pkg::ST_DELAY && startup_sel != 3'h0 |=> !code_run_out) // [R2]
    else $error("code released during start-up delay");
  a_key_ro_bus: assert property (wr_fire && reg_hit(aw_addr, cflg_pkg::IDX_KEY)
                                 |=> s_axi_bvalid_out && s_axi_bresp_out == 2'h2) // [R6]
    else $error("key write not refused");

endmodule

`default_nettype wire

// *** hw/cflg_pkg.sv ***
package cflg_pkg;

  // ==========================================================
  // lock key
  // ==========================================================
  localparam logic [31:0] UNLOCK_KEY = 32'h5cc5c55c;
  localparam logic [31:0] KEY_RESET = 32'h00000000;

  // ==========================================================
  // register indices; byte address is four times the index
  // ==========================================================
  localparam logic [5:0] IDX_KEY = 6'h00;
  localparam logic [5:0] IDX_SYS_CFG1 = 6'h06;
  localparam logic [5:0] IDX_CODE_SIZE = 6'h07;
  localparam logic [5:0] IDX_BOOT_SIZE = 6'h08;
  localparam logic [5:0] IDX_STATUS = 6'h09;
  localparam logic [5:0] IDX_CONTROL = 6'h0a;
  localparam int ADDR_W = 8;

  // ==========================================================
  // fuse fields and values held until the first load
  // ==========================================================
  localparam int SUPPLY_LSB = 3;
  localparam int STARTUP_LSB = 0;
  localparam logic [1:0] SUPPLY_DUAL = 2'h1;
  localparam logic [1:0] SUPPLY_SINGLE = 2'h2;
  localparam logic [2:0] STARTUP_NONE = 3'h0;
  localparam logic [7:0] FUSE_RESET = 8'h00;
  localparam logic [8:0] FLASH_BLOCKS_DEFAULT = 9'h080;

  // status bits and control bits
  localparam int ST_BIT_UNLOCKED = 0;
  localparam int ST_BIT_LOADED = 1;
  localparam int ST_BIT_RUNNING = 2;
  localparam int ST_BIT_ERASING = 3;
  localparam int CTL_BIT_RELOAD = 0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================
  // start-up delay timing
  // ==========================================================
  localparam int CLK_HZ = 125_000_000;
  localparam int STARTUP_UNIT_MS = 1;
  localparam int STARTUP_UNIT_CYCLES = CLK_HZ / 1000 * STARTUP_UNIT_MS;

  typedef enum logic [2:0] {
    SEC_FLASH = 3'h0,
    SEC_SRAM = 3'h1,
    SEC_EEPROM = 3'h2,
    SEC_SIGNATURE = 3'h3,
    SEC_USER_ROW = 3'h4,
    SEC_FUSE = 3'h5,
    SEC_LOCK = 3'h6,
    SEC_REGS = 3'h7
  } cflg_section_t;

  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN = 3'b100
  } cflg_state_t;

endpackage

// *** hw/cflg_access_check.sv ***
`timescale 1ns/1ps
`default_nettype none

module cflg_access_check (
  input wire logic is_host_in, // 1: debug host, 0: cpu
  input wire logic unlocked_in, // key matches unlock value
  input wire logic write_in, // 1: write, 0: read
  input wire logic fuse_cmd_in, // host write issued by fuse-write command
  input wire cflg_pkg::cflg_section_t section_in, // target section
  output logic allow_out // access permitted
);

  // ==========================================================
  // permission tables
  // ==========================================================
  wire logic sec_sign = (section_in == cflg_pkg::SEC_SIGNATURE);
  wire logic sec_user = (section_in == cflg_pkg::SEC_USER_ROW);
  wire logic sec_cfg = (section_in == cflg_pkg::SEC_FUSE) || (section_in == cflg_pkg::SEC_LOCK);

  // cpu never sees the lock; only the factory areas are write-barred
  wire logic cpu_allow = !write_in || !(sec_sign || sec_cfg); // [R9]
  wire logic host_open = !write_in || !sec_sign; // [R10]
  // locked host keeps a single door: user row write through the fuse command
  wire logic host_shut = write_in && sec_user && fuse_cmd_in; // [R11] [R13]
  wire logic host_allow = unlocked_in ? host_open : host_shut;

  assign allow_out = is_host_in ? host_allow : cpu_allow;

endmodule

`default_nettype wire

// *** test/cflg_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// key storage and array controller seen by the debug host
// ==========
module cflg_host_model #(
  parameter int ERASE_CYCLES = 6
) (
  input wire logic core_clk_in, // system clock
  input wire logic lock_req_in, // pulse: host stores a locking key
  input wire logic reload_req_in, // pulse: other storage changed
  input wire logic erase_start_in, // pulse: array erase begins
  input wire logic key_store_write_in, // pulse: erase writes key
  input wire logic [31:0] key_store_data_in, // key value to store
  output logic [31:0] nv_key_out, // stored key
  output logic nv_reload_out, // pulse: storage changed
  output logic erase_done_out // pulse: array erase finished
);
  int cnt = 0;
  initial nv_key_out = cflg_pkg::UNLOCK_KEY;
  initial nv_reload_out = 1'b0;
  initial erase_done_out = 1'b0;
  always @(posedge core_clk_in)
  begin
    nv_reload_out <= lock_req_in | reload_req_in;
    erase_done_out <= (cnt == 1);
    cnt <= erase_start_in ? ERASE_CYCLES : (cnt != 0 ? cnt - 1 : 0);
    if (lock_req_in)
      nv_key_out <= ~cflg_pkg::UNLOCK_KEY;
    if (key_store_write_in)
      nv_key_out <= key_store_data_in;
  end
endmodule
`default_nettype wire

// *** test/config_fuse_lock_access_gate_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module config_fuse_lock_access_gate_test;
  logic ck = 1'b0, rn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, sys = 8'h0a, bsz = 8'h00;
  logic [31:0] wd = 32'h0, key, rd;
  logic hv = 1'b0, hw = 1'b0, hf = 1'b0, cv = 1'b0, cw = 1'b0, er = 1'b0, lk = 1'b0, rl;
  logic ek = 1'b1;
  cflg_pkg::cflg_section_t sec = cflg_pkg::SEC_FLASH;
  logic awy, wy, bv, ary, rv, ha, hg, ca, cg, es, ee, ksw, unl, sd, ss, sr, run, ed;
  logic [1:0] bres, rres;
  logic [7:0] hrd;
  logic [8:0] bb, cb;
  logic [31:0] ksd;
  int miscompares = 0, n_checks = 0;
  always #4 ck = ~ck;
  cflg_host_model host_u (.core_clk_in(ck), .lock_req_in(lk), .reload_req_in(1'b0),
    .erase_start_in(es), .key_store_write_in(ksw), .key_store_data_in(ksd),
    .nv_key_out(key), .nv_reload_out(rl), .erase_done_out(ed));
  cflg_gate #(.STARTUP_UNIT_CYCLES(4)) dut_u (.core_clk_in(ck), .rst_n_in(rn),
    .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awy),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wy),
    .s_axi_bresp_out(bres), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(ary),
    .s_axi_rdata_out(rd), .s_axi_rresp_out(rres), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .nv_key_in(key), .nv_sys_cfg1_in(sys), .nv_code_size_in(8'h20), .nv_boot_size_in(bsz),
    .nv_eeprom_keep_in(ek), .nv_reload_in(rl), .host_req_valid_in(hv),
    .host_req_write_in(hw), .host_req_fuse_cmd_in(hf), .host_req_section_in(sec),
    .host_mem_rdata_in(8'h5a), .host_ack_out(ha), .host_grant_out(hg), .host_rdata_out(hrd),
    .host_erase_req_in(er), .cpu_req_valid_in(cv), .cpu_req_write_in(cw),
    .cpu_req_section_in(sec), .cpu_ack_out(ca), .cpu_grant_out(cg), .erase_start_out(es),
    .erase_eeprom_out(ee), .erase_done_in(ed), .key_store_write_out(ksw),
    .key_store_data_out(ksd), .unlocked_out(unl), .supply_dual_out(sd),
    .supply_single_out(ss), .supply_reserved_out(sr), .boot_blocks_out(bb),
    .code_blocks_out(cb), .code_run_out(run));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] ex, input logic [1:0] xr);
    logic ah, wh, dn;
    logic [1:0] r;
    logic [31:0] d;
    dn = 1'b0;
    @(posedge ck);
    awa <= a;
    ara <= a;
    wd <= ex;
    awv <= wr;
    wv <= wr;
    br <= wr;
    arv <= !wr;
    rr <= !wr;
    for (int i = 0; i < 50 && !dn; i++)
    begin
      @(negedge ck);
      ah = (awv && awy) || (arv && ary);
      wh = wv && wy;
      dn = wr ? bv : rv;
      r = wr ? bres : rres;
      d = rd;
      @(posedge ck);
      if (ah)
        {awv, arv} <= 2'b00;
      if (wh)
        wv <= 1'b0;
    end
    {br, rr} <= 2'b00;
    chk("resp", xr, r);
    if (!wr)
      chk("rdata", ex, d);
  endtask
  task automatic acc(input logic c, input logic w, input logic f, input int s, input logic eg);
    @(posedge ck);
    {cv, hv, cw, hw, hf} <= {c, !c, w, w, f};
    sec <= cflg_pkg::cflg_section_t'(s[2:0]);
    @(posedge ck);
    {cv, hv} <= 2'b00;
    #1;
    chk("ack", 32'h1, c ? ca : ha);
    chk("grant", eg, c ? cg : hg);
    if (!c)
      chk("host_rdata", (eg && !w) ? 32'h5a : 32'h0, hrd);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ck);
    miscompares++;
    report_and_stop();
  end
  // ==========
  // main sequence; start-up code 2 runs a 2-unit delay before code_run
  // ==========
  initial
  begin
    repeat (6) @(posedge ck);
    rn <= 1'b1;
    repeat (4) @(posedge ck);
    #1 chk("run_early", 0, run);
    repeat (10) @(posedge ck);
    #1 chk("run", 1, run);
    chk("unlocked", 1, unl);
    chk("code_blocks", 32'h80, cb);
    chk("boot_blocks", 32'h80, bb);
    bus(0, 8'h00, cflg_pkg::UNLOCK_KEY, cflg_pkg::RESP_OKAY);
    bus(0, 8'h18, 32'h0a, cflg_pkg::RESP_OKAY);
    bus(0, 8'h3c, 32'h0, cflg_pkg::RESP_DECERR);
    bus(1, 8'h1c, 32'h0, cflg_pkg::RESP_SLVERR);
    for (int s = 0; s < 8; s++)
    begin
      acc(0, 0, 0, s, 1);
      acc(0, 1, 0, s, s != 3);
      acc(1, 1, 0, s, !(s inside {3, 5, 6}));
    end
    for (int c = 0; c < 4; c++)
    begin
      @(posedge ck);
      sys <= 8'(c << 3);
      bsz <= 8'h05;
      bus(1, 8'h28, 32'h1, cflg_pkg::RESP_OKAY);
      repeat (3) @(posedge ck);
      #1 chk("supply", {c == 1, c == 2, c == 0 || c == 3}, {sd, ss, sr});
      chk("boot_blocks", 32'h5, bb);
      chk("code_blocks", 32'h20, cb);
    end
    @(posedge ck);
    lk <= 1'b1;
    @(posedge ck);
    lk <= 1'b0;
    repeat (3) @(posedge ck);
    #1 chk("unlocked", 0, unl);
    for (int s = 0; s < 8; s++)
    begin
      acc(0, 0, 0, s, 0);
      acc(0, 1, 0, s, 0);
      acc(1, 0, 0, s, 1);
    end
    acc(0, 1, 1, 4, 1);
    acc(0, 0, 1, 4, 0);
    @(posedge ck);
    er <= 1'b1;
    @(posedge ck);
    er <= 1'b0;
    #1 chk("erase_start", 1, es);
    chk("erase_eeprom", 1, ee);
    for (int i = 0; i < 50 && unl !== 1'b1; i++)
    begin
      @(posedge ck);
      #1;
    end
    chk("unlocked", 1, unl);
    @(posedge ck);
    er <= 1'b1;
    @(posedge ck);
    er <= 1'b0;
    #1 chk("erase_start", 1, es);
    chk("erase_eeprom", 0, ee);
    report_and_stop();
  end
endmodule
`default_nettype wire
